// [hdl/tswd_pkg.sv]
// constants and types for the two-stage watchdog
// How it works
// - interval 1..255, unit seconds or minutes
// - stage one NMI/init, stage two reset
// - missed strobe gives enabled NMI and/or reset
// - enableable flag records watchdog caused reset
// - control/status cleared at power-up; cause flag also by host clear
// - disabled watchdog starts no stage; a reset pulse already under way still runs to its end
// - low supply rail forces board reset
// - any register read or write clears counter, except during the reset pulse
// - stage one drives selected output high
package tswd_pkg;
   localparam int unsigned CLK_HZ       = 100_000_000;
   localparam int unsigned SEC_PER_MIN  = 60;
   localparam int unsigned CNT_W        = 8;
   localparam logic [7:0]  CNT_MIN      = 8'h01;
   localparam logic [7:0]  CNT_RST      = 8'hFF;
   localparam int unsigned RST_PULSE_NS = 1000;
   localparam int unsigned RST_PULSE_CYC = (RST_PULSE_NS * (CLK_HZ / 1_000_000) + 999) / 1000;

   typedef enum logic [3:0] {
      TSWD_IDLE  = 4'b0001,
      TSWD_RUN   = 4'b0010,
      TSWD_STG1  = 4'b0100,
      TSWD_RESET = 4'b1000
   } tswd_state_t;
endpackage : tswd_pkg

// [hdl/tswd_tick.sv]
// prescaler that yields one-cycle second and minute enables
module tswd_tick import tswd_pkg::*; #(
   parameter int unsigned CYC_PER_SEC = CLK_HZ
) (
   input  wire logic clk,      // system clock
   input  wire logic arst_n,   // async reset
   input  wire logic clr,      // restart prescaler on strobe
   output logic      sec_tick, // one-cycle second pulse
   output logic      min_tick  // one-cycle minute pulse
);
   logic [31:0] pre_r, pre_nxt;
   logic [5:0]  sec_r, sec_nxt;
   logic        sec_nxt_t, min_nxt_t;

   always_comb begin
      pre_nxt   = pre_r + 32'h1;
      sec_nxt   = sec_r;
      sec_nxt_t = 1'b0;
      min_nxt_t = 1'b0;
      if (clr) begin
         pre_nxt = '0;
         sec_nxt = '0;
      end else if (pre_r == 32'(CYC_PER_SEC - 1)) begin
         pre_nxt   = '0;
         sec_nxt_t = 1'b1;
         if (sec_r == 6'(SEC_PER_MIN - 1)) begin
            sec_nxt   = '0;
            min_nxt_t = 1'b1;
         end else begin
            sec_nxt = sec_r + 6'h1;
         end
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         pre_r    <= '0;
         sec_r    <= '0;
         sec_tick <= 1'b0;
         min_tick <= 1'b0;
      end else begin
         pre_r    <= pre_nxt;
         sec_r    <= sec_nxt;
         sec_tick <= sec_nxt_t;
         min_tick <= min_nxt_t;
      end
   end
endmodule : tswd_tick

// [hdl/tswd_top.sv]
// two-stage watchdog with reset-cause flag and supply reset merge
module tswd_top import tswd_pkg::*; #(
   parameter int unsigned CYC_PER_SEC = CLK_HZ,
   parameter int unsigned RST_CYC     = RST_PULSE_CYC
) (
   input  wire logic         clk,         // 100 MHz system clock
   input  wire logic         arst_n,      // power-on reset, async
   input  wire logic         reg_rd,      // host read of watchdog register
   input  wire logic         reg_wr,      // host write of watchdog register
   input  wire logic         wd_en,       // monitoring enable
   input  wire logic         unit_min,    // 1: minutes, 0: seconds
   input  wire logic [7:0]   period,      // interval count 1..255
   input  wire logic         stg1_en,     // first stage output enable
   input  wire logic         sel_init,    // 1: init request, 0: NMI
   input  wire logic         rst_en,      // second stage reset enable
   input  wire logic         cause_en,    // reset-cause recording enable
   input  wire logic         cause_clr,   // host clear of cause flag
   input  wire logic         uv_5v,       // 5 V rail below limit
   input  wire logic         uv_3v3,      // 3.3 V rail below limit
   input  wire logic         uv_12v,      // 12 V rail below limit
   output logic              nmi,         // non-maskable interrupt, high
   output logic              cpu_init,    // processor init request, high
   output logic              board_rst,   // board hard reset, high
   output logic              wd_cause,    // watchdog caused last reset
   output logic              wd_active    // watchdog counting
);
   tswd_state_t st_r, st_nxt;
   logic [7:0]  cnt_r, cnt_nxt;
   logic [15:0] rp_r, rp_nxt;
   logic        cause_r, cause_nxt;
   logic        sec_tick, min_tick, tick, strobe, uv_any;
   logic [7:0]  per_eff;
   logic        nmi_nxt, init_nxt, brst_nxt;

   assign strobe  = reg_rd | reg_wr;
   assign tick    = unit_min ? min_tick : sec_tick;
   assign per_eff = (period < CNT_MIN) ? CNT_MIN : period;
   assign uv_any  = uv_5v | uv_3v3 | uv_12v;

   tswd_tick #(.CYC_PER_SEC(CYC_PER_SEC)) u_tick (
      .clk      (clk),
      .arst_n   (arst_n),
      .clr      (strobe || st_r == TSWD_IDLE),
      .sec_tick (sec_tick),
      .min_tick (min_tick)
   );

   always_comb begin
      st_nxt    = st_r;
      cnt_nxt   = cnt_r;
      rp_nxt    = rp_r;
      cause_nxt = cause_r;
      if (cause_clr) cause_nxt = 1'b0;
      unique case (st_r)
         TSWD_IDLE: begin
            cnt_nxt = '0;
            if (wd_en) st_nxt = TSWD_RUN;
         end
         TSWD_RUN: begin
            if (strobe) cnt_nxt = '0;
            else if (tick) begin
               cnt_nxt = cnt_r + 8'h1;
               if (cnt_r + 8'h1 >= per_eff) begin
                  cnt_nxt = '0;
                  st_nxt  = TSWD_STG1;
               end
            end
         end
         TSWD_STG1: begin
            if (strobe) begin
               cnt_nxt = '0;
               st_nxt  = TSWD_RUN;
            end else if (tick) begin
               cnt_nxt = cnt_r + 8'h1;
               if (cnt_r + 8'h1 >= per_eff && rst_en) begin
                  st_nxt = TSWD_RESET;
                  rp_nxt = 16'(RST_CYC);
                  if (cause_en) cause_nxt = 1'b1;
               end else if (cnt_r + 8'h1 >= per_eff) begin
                  cnt_nxt = '0;
               end
            end
         end
         TSWD_RESET: begin
            if (rp_r <= 16'h1) begin
               rp_nxt  = '0;
               cnt_nxt = '0;
               st_nxt  = TSWD_IDLE;
            end else begin
               rp_nxt = rp_r - 16'h1;
            end
         end
         default: st_nxt = TSWD_IDLE;
      endcase
      if (!wd_en && st_r != TSWD_RESET) begin
         st_nxt  = TSWD_IDLE;
         cnt_nxt = '0;
      end
      // outputs follow the next state so they rise on the same edge as the state
      nmi_nxt  = (st_nxt == TSWD_STG1) && stg1_en && !sel_init;
      init_nxt = (st_nxt == TSWD_STG1) && stg1_en && sel_init;
      brst_nxt = (st_nxt == TSWD_RESET) || uv_any;
   end

   // only power-on reset clears state; the cause flag survives the board reset
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         st_r      <= TSWD_IDLE;
         cnt_r     <= '0;
         rp_r      <= '0;
         cause_r   <= 1'b0;
         nmi       <= 1'b0;
         cpu_init  <= 1'b0;
         board_rst <= 1'b0;
      end else begin
         st_r      <= st_nxt;
         cnt_r     <= cnt_nxt;
         rp_r      <= rp_nxt;
         cause_r   <= cause_nxt;
         nmi       <= nmi_nxt;
         cpu_init  <= init_nxt;
         board_rst <= brst_nxt;
      end
   end

   assign wd_cause  = cause_r;
   assign wd_active = (st_r != TSWD_IDLE);

   a_uv_forces_rst: assert property (@(posedge clk) disable iff (!arst_n)
      uv_any |=> board_rst) else $error("undervoltage did not reset board");
   a_off_no_nmi: assert property (@(posedge clk) disable iff (!arst_n)
      !wd_en [*2] |-> !nmi && !cpu_init) else $error("disabled watchdog fired");
   a_strobe_clears: assert property (@(posedge clk) disable iff (!arst_n)
      strobe && st_r == TSWD_RUN && wd_en |=> cnt_r == 8'h00)
      else $error("strobe did not clear counter");
   a_stg1_before_rst: assert property (@(posedge clk) disable iff (!arst_n)
      st_r != TSWD_RESET ##1 st_r == TSWD_RESET |-> $past(st_r) == TSWD_STG1)
      else $error("reset without first stage");
   a_nmi_sel: assert property (@(posedge clk) disable iff (!arst_n)
      st_r == TSWD_STG1 && $past(stg1_en) && !$past(sel_init) && $past(st_r) == TSWD_STG1
      |-> nmi && !cpu_init) else $error("wrong first stage output");
   a_stg1_strobe: assert property (@(posedge clk) disable iff (!arst_n)
      st_r == TSWD_STG1 && strobe && wd_en |=> st_r == TSWD_RUN)
      else $error("strobe did not cancel pending reset");
   a_cause_set: assert property (@(posedge clk) disable iff (!arst_n)
      st_r == TSWD_STG1 && st_nxt == TSWD_RESET && cause_en |=> wd_cause)
      else $error("reset cause not recorded");
   a_cause_hold: assert property (@(posedge clk) disable iff (!arst_n)
      wd_cause && !cause_clr |=> wd_cause) else $error("cause flag lost");
   a_rst_out: assert property (@(posedge clk) disable iff (!arst_n)
      st_r == TSWD_RESET |-> board_rst) else $error("reset state without reset");
   a_tick_unit: assert property (@(posedge clk) disable iff (!arst_n)
      st_r == TSWD_RUN && !strobe && !tick && wd_en |=> cnt_r == $past(cnt_r))
      else $error("counter moved without tick");

   // output selection and gating by the enable bits
   a_init_sel: assert property (@(posedge clk) disable iff (!arst_n)
      st_r == TSWD_STG1 && $past(stg1_en) && $past(sel_init) && $past(st_r) == TSWD_STG1
      |-> cpu_init && !nmi) else $error("wrong first stage output");
   a_stg1_gated: assert property (@(posedge clk) disable iff (!arst_n)
      !stg1_en |=> !nmi && !cpu_init)
      else $error("first stage output while not enabled");
   a_rst_gated: assert property (@(posedge clk) disable iff (!arst_n)
      st_r == TSWD_STG1 && !rst_en |=> st_r != TSWD_RESET)
      else $error("reset while not enabled");
   a_cause_gated: assert property (@(posedge clk) disable iff (!arst_n)
      !cause_en && !wd_cause |=> !wd_cause)
      else $error("cause flag set while not enabled");

   // quiet states and the disable path
   a_idle_quiet: assert property (@(posedge clk) disable iff (!arst_n)
      st_r == TSWD_IDLE |-> !nmi && !cpu_init)
      else $error("idle watchdog drives first stage");
   a_off_to_idle: assert property (@(posedge clk) disable iff (!arst_n)
      !wd_en && st_r != TSWD_RESET |=> st_r == TSWD_IDLE)
      else $error("disable did not stop watchdog");
   a_arm_run: assert property (@(posedge clk) disable iff (!arst_n)
      st_r == TSWD_IDLE && wd_en |=> st_r == TSWD_RUN)
      else $error("enable did not arm watchdog");
   a_idle_cnt: assert property (@(posedge clk) disable iff (!arst_n)
      st_r == TSWD_IDLE |=> cnt_r == 8'h00)
      else $error("counter not cleared from idle");
   a_run_quiet: assert property (@(posedge clk) disable iff (!arst_n)
      st_r == TSWD_RUN |-> !nmi && !cpu_init)
      else $error("first stage output while counting");

   // sequencing of the two stages and the reset pulse
   a_state_onehot: assert property (@(posedge clk) disable iff (!arst_n)
      $onehot(st_r))
      else $error("state code not one-hot");
   a_rst_holds: assert property (@(posedge clk) disable iff (!arst_n)
      st_r == TSWD_RESET && rp_r > 16'h1 |=> st_r == TSWD_RESET)
      else $error("reset pulse cut short");
   a_rst_ends: assert property (@(posedge clk) disable iff (!arst_n)
      st_r == TSWD_RESET && rp_r <= 16'h1 |=> st_r == TSWD_IDLE)
      else $error("reset pulse did not end");
   a_cancel_rst: assert property (@(posedge clk) disable iff (!arst_n)
      st_r == TSWD_STG1 && strobe && !uv_any |=> !board_rst)
      else $error("reset after cancelling strobe");
   a_stg1_hold: assert property (@(posedge clk) disable iff (!arst_n)
      st_r == TSWD_STG1 && !strobe && !tick && wd_en |=> st_r == TSWD_STG1)
      else $error("first stage left without event");

   // prescaler behaviour seen from the top
   a_strobe_pre: assert property (@(posedge clk) disable iff (!arst_n)
      strobe |=> !sec_tick && !min_tick)
      else $error("tick right after strobe");
   a_min_on_sec: assert property (@(posedge clk) disable iff (!arst_n)
      min_tick |-> sec_tick)
      else $error("minute tick off a second boundary");

   c_stage1: cover property (@(posedge clk) disable iff (!arst_n) st_r == TSWD_STG1);
   c_reset: cover property (@(posedge clk) disable iff (!arst_n) st_r == TSWD_RESET);
   c_cancel: cover property (@(posedge clk) disable iff (!arst_n)
      st_r == TSWD_STG1 ##1 st_r == TSWD_RUN);
   c_uv: cover property (@(posedge clk) disable iff (!arst_n) uv_any);
   c_init: cover property (@(posedge clk) disable iff (!arst_n)
      st_r == TSWD_STG1 && cpu_init);
endmodule : tswd_top

// [dv/tswd_host.sv]
// host model that strobes the watchdog register
module tswd_host (
   input  wire logic clk,    // system clock
   output logic      reg_rd, // read strobe
   output logic      reg_wr  // write strobe
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      reg_rd = 1'b0;
      reg_wr = 1'b0;
   end
   // one-cycle pulse; read and write both count as a strobe
   task automatic strobe(input logic wr);
      @(negedge clk);
      reg_rd = !wr;
      reg_wr = wr;
      @(negedge clk);
      reg_rd = 1'b0;
      reg_wr = 1'b0;
   endtask : strobe
endmodule : tswd_host

// [dv/tswd_top_tb.sv]
// self-checking bench for the two-stage watchdog
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin err_count++; \
   $display("CHECK FAILED t=%0t got %h exp %h", $time, a, b); end end
module tswd_top_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'b0, arst_n = 1'b0, rd, wr, en = 1'b0, umin = 1'b0, se = 1'b1;
   logic si = 1'b0, re = 1'b1, ce = 1'b1, cc = 1'b0;
   logic [2:0] uv = 3'h0;
   logic [7:0] per = 8'h02;
   logic nmi, init, brst, cause, act;
   int err_count = 0, check_count = 0, n;
   always #5 clk = ~clk;
   tswd_host host (.clk(clk), .reg_rd(rd), .reg_wr(wr));
   // short second keeps a minute within the run budget
   tswd_top #(.CYC_PER_SEC(10), .RST_CYC(8)) dut (.clk(clk), .arst_n(arst_n),
      .reg_rd(rd), .reg_wr(wr), .wd_en(en), .unit_min(umin), .period(per),
      .stg1_en(se), .sel_init(si), .rst_en(re), .cause_en(ce), .cause_clr(cc),
      .uv_5v(uv[0]), .uv_3v3(uv[1]), .uv_12v(uv[2]), .nmi(nmi), .cpu_init(init),
      .board_rst(brst), .wd_cause(cause), .wd_active(act));
   task automatic results;
      if (err_count == 0 && check_count > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : results
   task automatic wait_hi(ref logic s, input int lim);
      n = 0;
      while (s !== 1'b1) begin
         @(negedge clk);
         n++;
         if (n > lim) begin
            err_count++;
            results();
         end
      end
   endtask : wait_hi
   task automatic idle_all;
      @(negedge clk);
      en = 1'b0;
      repeat (3) @(negedge clk);
   endtask : idle_all
   initial begin
      repeat (16) @(negedge clk);
      arst_n = 1'b1;
      `CHK({nmi, init, brst, cause}, 4'h0)
      repeat (100) @(negedge clk);
      `CHK({nmi, init, brst, act}, 4'h0)
      en = 1'b1;
      wait_hi(nmi, 40);
      `CHK(n >= 19 && n <= 24, 1'b1)
      `CHK({init, brst}, 2'h0)
      wait_hi(brst, 40);
      `CHK(n >= 18 && n <= 23, 1'b1)
      en = 1'b0;
      wait_hi(cause, 3);
      repeat (12) @(negedge clk);
      `CHK({brst, cause}, 2'h1)
      cc = 1'b1;
      @(negedge clk);
      cc = 1'b0;
      @(negedge clk);
      `CHK(cause, 1'b0)
      si = 1'b1;
      en = 1'b1;
      // strobes well inside the interval hold off both stages
      for (int i = 0; i < 6; i++) begin
         repeat (10) @(negedge clk);
         host.strobe(i[0]);
      end
      `CHK({nmi, init, brst}, 3'h0)
      wait_hi(init, 40);
      `CHK(nmi, 1'b0)
      host.strobe(1'b0);
      @(negedge clk);
      `CHK(init, 1'b0)
      repeat (15) @(negedge clk);
      host.strobe(1'b1);
      repeat (15) @(negedge clk);
      `CHK(brst, 1'b0)
      idle_all();
      umin = 1'b1;
      per = 8'h01;
      en = 1'b1;
      repeat (500) @(negedge clk);
      `CHK(init, 1'b0)
      wait_hi(init, 130);
      idle_all();
      // each rail forces the reset with the watchdog off
      for (int i = 0; i < 3; i++) begin
         uv = 3'h1 << i;
         repeat (2) @(negedge clk);
         `CHK(brst, 1'b1)
         uv = 3'h0;
         repeat (12) @(negedge clk);
         `CHK({brst, cause}, 2'h0)
      end
      // stage outputs and cause recording switched off
      se = 1'b0;
      re = 1'b0;
      ce = 1'b0;
      umin = 1'b0;
      en = 1'b1;
      repeat (2) @(negedge clk);
      `CHK(act, 1'b1)
      repeat (60) @(negedge clk);
      `CHK({nmi, init, brst, cause}, 4'h0)
      re = 1'b1;
      wait_hi(brst, 40);
      `CHK(cause, 1'b0)
      idle_all();
      repeat (12) @(negedge clk);
      `CHK({brst, act}, 2'h0)
      results();
   end
endmodule : tswd_top_tb
